// File: hw/tmr_pkg.sv
// shared constants, register map and state types of the reload timer
package tmr_pkg;
  // register byte offsets
  localparam logic [7:0] TMR_OFF_CTRL = 8'h00;
  localparam logic [7:0] TMR_OFF_MODE = 8'h04;
  localparam logic [7:0] TMR_OFF_COUNT = 8'h08;
  localparam logic [7:0] TMR_OFF_RELOAD = 8'h0C;
  localparam logic [7:0] TMR_OFF_VECTOR = 8'h10;
  // timer_control_reg bit positions
  localparam int TMR_CTRL_OVF = 7;
  localparam int TMR_CTRL_EXT = 6;
  localparam int TMR_CTRL_SSEL_HI = 5;
  localparam int TMR_CTRL_SSEL_LO = 4;
  localparam int TMR_CTRL_EXEN = 3;
  localparam int TMR_CTRL_RUN = 2;
  localparam int TMR_CTRL_CTS = 1;
  localparam int TMR_CTRL_CPRL = 0;
  // timer_mode_reg bit positions
  localparam int TMR_MODE_OVF_SC = 5;
  localparam int TMR_MODE_EXT_SC = 4;
  localparam int TMR_MODE_PRE_HI = 3;
  localparam int TMR_MODE_PRE_LO = 2;
  localparam int TMR_MODE_OE = 1;
  localparam int TMR_MODE_DOWN_COUNT_ENABLE = 0;
  // vectoring acknowledge bits
  localparam int TMR_VEC_OVF = 0;
  localparam int TMR_VEC_EXT = 1;
  // values
  localparam logic [15:0] TMR_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TMR_COUNT_ONE = 16'h0001;
  localparam logic [15:0] TMR_COUNT_RST = 16'h0000;
  localparam logic [3:0] TMR_PRE_STATES = 4'h3;
  localparam logic [1:0] TMR_SSEL_NONE = 2'h0;
  localparam logic TMR_HRESP_OKAY = 1'b0;
  localparam int TMR_HTRANS_ACTIVE = 1;

  typedef enum logic [4:0] {
    TMR_AUTO = 5'h01,
    TMR_CLKOUT = 5'h02,
    TMR_CAPTURE = 5'h04,
    TMR_STOPPED = 5'h08,
    TMR_BAUD = 5'h10
  } tmr_mode_t;

  typedef struct packed {
    logic ovf;
    logic ext;
    logic [1:0] ssel;
    logic exen;
    logic run;
    logic cts;
    logic cprl;
    logic ovf_sc;
    logic ext_sc;
    logic [1:0] pre;
    logic oe;
    logic down_count_enable;
    logic [15:0] count;
    logic [15:0] reload;
    logic clk_out;
    logic irq;
    logic baud_tick;
    logic ready;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic ext_prev;
    logic cin_prev;
  } tmr_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } tmr_pre_state_t;

  // serial select wins, then capture/reload select and output enable
  function automatic tmr_mode_t tmr_decode(input logic [1:0] ssel, input logic cprl, input logic oe);
    tmr_mode_t m;
    m = TMR_AUTO;
    if (ssel != TMR_SSEL_NONE) begin
      m = TMR_BAUD;
    end else if (cprl && oe) begin
      m = TMR_STOPPED;
    end else if (cprl) begin
      m = TMR_CAPTURE;
    end else if (oe) begin
      m = TMR_CLKOUT;
    end
    return m;
  endfunction
endpackage

// File: hw/tmr_prescale.sv
// prescaler: one tick every three times (prescale plus one) clocks while running
`timescale 1ns/100ps
`default_nettype none
module tmr_prescale
  import tmr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [1:0] prescale,
  output logic tick
);
  tmr_pre_state_t s;
  tmr_pre_state_t n;
  logic [3:0] limit;

  always_comb begin
    limit = 4'((4'(prescale) + 4'h1) * TMR_PRE_STATES) - 4'h1; // RL9
    n = s;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 4'h0;
    end else if (s.cnt >= limit) begin
      n.cnt = 4'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

// File: hw/tmr_reload_timer.sv
// sixteen-bit reload timer with clock-out and bit-rate tick, behind an AHB-Lite slave
//
// Contract
// RL1 - up count, no external enable: wrap at FFFF sets overflow, loads reload pair
// RL2 - external enable: falling edge on event pin also reloads, sets external flag
// RL3 - up counting: interrupt request while overflow or external flag is set
// RL4 - down enable, pin high: count up, wrap at FFFF, flag, interrupt, reload
// RL5 - down enable, pin low: count down; at reload value flag and load FFFF
// RL6 - up/down: external flag toggles on each wrap as count bit 17, no interrupt
// RL7 - clock-out mode: count to wrap, reload from pair, no interrupt
// RL8 - output enable set, counter select clear: each wrap toggles divide-by-two stage driving clock-out pin
// RL9 - timer input is system clock over three times (prescale plus one)
// RL10 - software sets enable, clears select, writes reload, count, then run bit
// RL11 - clock-out and bit-rate ticks may run together from one reload pair
// RL12 - serial select nonzero: bit-rate mode, high byte rollover reloads both bytes
// RL13 - bit-rate mode: high byte rollover leaves overflow flag alone
// RL14 - bit-rate mode: event pin edge sets external flag without reload
// RL15 - software stops the timer before touching count or reload registers
// RL16 - in bit-rate mode software never writes count, or reload, while running
// RL17 - prescale zero, reload FFE8 at 11.0592MHz gives 9600 baud, scaling likewise
// RL18 - mode decode: serial select, else select/enable give reload, clock-out, capture, stop
// RL19 - reset clears down enable, so the timer starts as an up counter
// RL20 - flags stay set until software clears them or vectoring clears them
`timescale 1ns/100ps
`default_nettype none
module tmr_reload_timer
  import tmr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ext_event_pin,
  input wire logic count_in_pin,
  output logic clock_out_pin,
  output logic timer_irq,
  output logic baud_tick
);
  localparam tmr_state_t TMR_STATE_RST = '{ready: 1'b1, default: '0};

  tmr_state_t s;
  tmr_state_t n;
  tmr_mode_t mode;
  logic pre_tick;
  logic tick;
  logic step;
  logic down;
  logic wrap;
  logic ext_fall;
  logic acc;

  function automatic logic [31:0] tmr_read(input tmr_state_t st, input logic [7:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (addr)
      TMR_OFF_CTRL: d[7:0] = {st.ovf, st.ext, st.ssel, st.exen, st.run, st.cts, st.cprl};
      TMR_OFF_MODE: d[5:0] = {st.ovf_sc, st.ext_sc, st.pre, st.oe, st.down_count_enable};
      TMR_OFF_COUNT: d[15:0] = st.count;
      TMR_OFF_RELOAD: d[15:0] = st.reload;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  tmr_prescale u_prescale (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(s.run),
    .prescale(s.pre),
    .tick(pre_tick)
  );

  always_comb begin
    n = s;
    n.baud_tick = 1'b0;
    mode = tmr_decode(s.ssel, s.cprl, s.oe); // RL18
    // counter select picks falling edges of the count pin instead of the prescaler
    tick = s.cts ? (s.cin_prev & ~count_in_pin) : pre_tick; // RL9
    step = s.run & tick & (mode != TMR_STOPPED);
    down = (mode == TMR_AUTO) & s.down_count_enable & ~ext_event_pin; // RL5
    ext_fall = s.ext_prev & ~ext_event_pin;
    acc = hsel & hready & htrans[TMR_HTRANS_ACTIVE];
    wrap = 1'b0;
    n.ext_prev = ext_event_pin;
    n.cin_prev = count_in_pin;

    // data phase of a write; accepted even while running, software keeps it safe
    if (s.wr_pend) begin // RL15 RL16
      unique case (s.wr_addr)
        TMR_OFF_CTRL: begin
          n.ovf = hwdata[TMR_CTRL_OVF];
          n.ext = hwdata[TMR_CTRL_EXT];
          n.ssel = hwdata[TMR_CTRL_SSEL_HI:TMR_CTRL_SSEL_LO];
          n.exen = hwdata[TMR_CTRL_EXEN];
          n.run = hwdata[TMR_CTRL_RUN];
          n.cts = hwdata[TMR_CTRL_CTS];
          n.cprl = hwdata[TMR_CTRL_CPRL];
        end
        TMR_OFF_MODE: begin
          n.ovf_sc = hwdata[TMR_MODE_OVF_SC];
          n.ext_sc = hwdata[TMR_MODE_EXT_SC];
          n.pre = hwdata[TMR_MODE_PRE_HI:TMR_MODE_PRE_LO];
          n.oe = hwdata[TMR_MODE_OE];
          n.down_count_enable = hwdata[TMR_MODE_DOWN_COUNT_ENABLE];
        end
        TMR_OFF_COUNT: n.count = hwdata[15:0];
        TMR_OFF_RELOAD: n.reload = hwdata[15:0];
        TMR_OFF_VECTOR: begin
          // vectoring clears a flag only when its software-clear option is off
          if (hwdata[TMR_VEC_OVF] && !s.ovf_sc) begin // RL20
            n.ovf = 1'b0;
          end
          if (hwdata[TMR_VEC_EXT] && !s.ext_sc) begin // RL20
            n.ext = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // counting; hardware events below override a same-cycle software clear
    if (step) begin
      if (down) begin
        if (s.count == s.reload) begin // RL5
          n.count = TMR_COUNT_MAX;
          wrap = 1'b1;
        end else begin
          n.count = s.count - TMR_COUNT_ONE;
        end
      end else if (s.count == TMR_COUNT_MAX) begin // RL1 RL4 RL12
        // capture mode is a free-running counter, everything else reloads
        n.count = (mode == TMR_CAPTURE) ? TMR_COUNT_RST : s.reload; // RL7
        wrap = 1'b1;
      end else begin
        n.count = s.count + TMR_COUNT_ONE;
      end
    end

    if (wrap) begin
      unique case (mode)
        TMR_AUTO: begin
          n.ovf = 1'b1; // RL1 RL4 RL5
          if (s.down_count_enable) begin
            n.ext = ~s.ext; // RL6
          end
        end
        TMR_CAPTURE: n.ovf = 1'b1;
        TMR_BAUD: n.baud_tick = 1'b1; // RL12 RL13 RL17
        TMR_CLKOUT: ; // RL7
        TMR_STOPPED: ;
      endcase
      // one reload pair serves both outputs, so the two rates are locked
      if (s.oe && !s.cts) begin
        n.clk_out = ~s.clk_out; // RL8 RL11
      end
    end

    // event pin edge; in up/down the pin is the direction, not an event
    if (ext_fall && s.exen && !((mode == TMR_AUTO) && s.down_count_enable)) begin
      n.ext = 1'b1; // RL2 RL14
      if (mode == TMR_AUTO) begin
        n.count = s.reload; // RL2
      end else if (mode == TMR_CAPTURE) begin
        n.reload = s.count;
      end
    end

    n.irq = n.ovf | (n.ext & ~n.down_count_enable); // RL3 RL6

    // address phase; read data taken after the pending write is merged
    n.wr_pend = acc & hwrite;
    n.wr_addr = haddr[7:0];
    if (acc && !hwrite) begin
      n.rdata = tmr_read(n, haddr[7:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= TMR_STATE_RST; // RL19
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.ready;
  assign hrdata = s.rdata;
  assign hresp = TMR_HRESP_OKAY;
  assign clock_out_pin = s.clk_out;
  assign timer_irq = s.irq;
  assign baud_tick = s.baud_tick;

  // helper: cycles between prescaler ticks
  logic [4:0] gap;
  logic gap_valid;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 5'h00;
      gap_valid <= 1'b0;
    end else if (!s.run) begin
      gap <= 5'h00;
      gap_valid <= 1'b0;
    end else if (pre_tick) begin
      gap <= 5'h01;
      gap_valid <= 1'b1;
    end else begin
      gap <= gap + 5'h01;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_up_wrap_reload: assert property (step && mode == TMR_AUTO && !s.down_count_enable && s.count == TMR_COUNT_MAX && !s.wr_pend
    |=> s.count == $past(s.reload) && s.ovf) else $error("up wrap did not reload or flag"); // RL1
  a_ext_edge_reload: assert property (mode == TMR_AUTO && !s.down_count_enable && s.exen && ext_fall && !s.wr_pend
    |=> s.count == $past(s.reload) && s.ext) else $error("event edge did not reload"); // RL2
  a_irq_follows_flags: assert property (timer_irq == (s.ovf || (s.ext && !s.down_count_enable)))
    else $error("interrupt request disagrees with flags"); // RL3
  a_down_underflow: assert property (step && mode == TMR_AUTO && s.down_count_enable && !ext_event_pin
    && s.count == s.reload && !s.wr_pend |=> s.count == TMR_COUNT_MAX && s.ovf)
    else $error("underflow did not load all ones"); // RL5
  a_updown_toggle: assert property (wrap && mode == TMR_AUTO && s.down_count_enable && !s.wr_pend
    |=> s.ext != $past(s.ext) && !($rose(s.ext) && timer_irq && !s.ovf))
    else $error("external flag did not toggle"); // RL6
  a_clkout_quiet: assert property (wrap && mode == TMR_CLKOUT && !s.ovf && !s.wr_pend
    |=> !s.ovf && s.count == $past(s.reload)) else $error("clock-out wrap raised overflow"); // RL7
  a_clkout_toggle: assert property (wrap && s.oe && !s.cts |=> clock_out_pin != $past(clock_out_pin))
    else $error("clock-out stage did not toggle"); // RL8
  a_prescale_gap: assert property (pre_tick && gap_valid && !s.cts && $stable(s.pre)
    |-> gap == 5'((5'(s.pre) + 5'h01) * 5'(TMR_PRE_STATES))) else $error("prescaler period wrong"); // RL9
  a_baud_no_flag: assert property (wrap && mode == TMR_BAUD && !s.ovf && !s.wr_pend
    |=> !s.ovf && baud_tick && s.count == $past(s.reload)) else $error("bit-rate wrap wrong"); // RL12 RL13
  a_baud_edge_flag: assert property (mode == TMR_BAUD && s.exen && ext_fall && !step && !s.wr_pend
    |=> s.ext && s.count == $past(s.count)) else $error("bit-rate edge reloaded"); // RL14
  a_flag_holds: assert property (s.ovf && !s.wr_pend |=> s.ovf) else $error("overflow flag dropped"); // RL20

  // helper: cycles between bit-rate ticks; any write restarts the measurement
  logic [19:0] bgap;
  logic bgap_valid;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bgap <= 20'h00000;
      bgap_valid <= 1'b0;
    end else if (!s.run || mode != TMR_BAUD || s.wr_pend) begin
      bgap <= 20'h00000;
      bgap_valid <= 1'b0;
    end else if (baud_tick) begin
      bgap <= 20'h00001;
      bgap_valid <= 1'b1;
    end else begin
      bgap <= bgap + 20'h00001;
    end
  end

  // the bit rate scales with prescale and with the distance of the reload pair from the top
  a_baud_period: assert property (baud_tick && bgap_valid && !s.cts // RL17
    |-> bgap == 20'((20'(s.pre) + 20'h00001) * 20'(TMR_PRE_STATES) * (20'h10000 - 20'(s.reload))))
    else $error("bit-rate period wrong");
  a_up_step: assert property (step && !down && s.count != TMR_COUNT_MAX // RL1
    && !(ext_fall && s.exen) && !s.wr_pend |=> s.count == $past(s.count) + TMR_COUNT_ONE)
    else $error("up step wrong");
  a_down_step: assert property (step && down && s.count != s.reload && !s.wr_pend // RL5
    |=> s.count == $past(s.count) - TMR_COUNT_ONE)
    else $error("down step wrong");
  a_stopped_hold: assert property (mode == TMR_STOPPED && !s.wr_pend // RL18
    |=> $stable(s.count))
    else $error("stopped timer moved");
  a_updown_quiet: assert property (s.down_count_enable && !s.ovf // RL6
    |-> !timer_irq)
    else $error("up/down external flag raised interrupt");
  a_tick_only_baud: assert property (!(wrap && mode == TMR_BAUD) // RL12
    |=> !baud_tick)
    else $error("bit-rate tick without wrap");
  a_tick_single: assert property (baud_tick // RL12
    |=> !baud_tick)
    else $error("bit-rate tick longer than one cycle");
  a_clkout_steady: assert property (!wrap // RL8
    |=> $stable(clock_out_pin))
    else $error("clock-out moved without wrap");
  a_vector_clear: assert property (s.wr_pend && s.wr_addr == TMR_OFF_VECTOR && hwdata[TMR_VEC_OVF] // RL20
    && !s.ovf_sc && !wrap |=> !s.ovf)
    else $error("vectoring did not clear overflow");
  a_sw_clear_only: assert property (s.wr_pend && s.wr_addr == TMR_OFF_VECTOR && s.ovf_sc && s.ovf // RL20
    |=> s.ovf)
    else $error("vectoring cleared a software-owned flag");
  a_ext_ignored: assert property (!s.exen && !s.down_count_enable && !s.ext && !s.wr_pend // RL2
    |=> !s.ext)
    else $error("external flag set while disabled");
  a_bus_ready: assert property (hreadyout && !hresp) else $error("bus stalled or refused"); // RL16

  c_baud_tick: cover property (mode == TMR_BAUD ##1 baud_tick);
  c_clock_out: cover property ($rose(clock_out_pin) ##[1:200] $fell(clock_out_pin));
  c_underflow: cover property (step && down && s.count == s.reload);
  c_ext_reload: cover property (mode == TMR_AUTO && s.exen && ext_fall);
  c_capture_wrap: cover property (wrap && mode == TMR_CAPTURE);
endmodule
`default_nettype wire

// File: tb/tmr_partner.sv
// far-side model: event pin driver and clock-out consumer
`timescale 1ns/100ps
`default_nettype none
module tmr_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic dir_level,
  input wire logic fall_req,
  input wire logic clock_out_pin,
  output logic ext_event_pin,
  output logic count_in_pin,
  output logic [7:0] hi_len,
  output logic [7:0] lo_len
);
  logic [7:0] run_len;
  logic last_clk;
  // counter input mode not exercised here
  assign count_in_pin = 1'b1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_event_pin <= 1'b1;
      last_clk <= 1'b0;
      run_len <= 8'h01;
      hi_len <= 8'h00;
      lo_len <= 8'h00;
    end else begin
      ext_event_pin <= dir_level & ~fall_req;
      last_clk <= clock_out_pin;
      if (clock_out_pin != last_clk) begin
        run_len <= 8'h01;
        if (last_clk) begin
          hi_len <= run_len;
        end else begin
          lo_len <= run_len;
        end
      end else begin
        run_len <= run_len + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tmr_reload_timer_tb.sv
// self-checking bench of the reload timer
`timescale 1ns/100ps
`default_nettype none
module tmr_reload_timer_tb
  import tmr_pkg::*;
;
  localparam logic [31:0] C_OVF = 32'h1 << TMR_CTRL_OVF;
  localparam logic [31:0] C_EXT = 32'h1 << TMR_CTRL_EXT;
  localparam logic [31:0] C_SS = 32'h1 << TMR_CTRL_SSEL_LO;
  localparam logic [31:0] C_EXEN = 32'h1 << TMR_CTRL_EXEN;
  localparam logic [31:0] C_RUN = 32'h1 << TMR_CTRL_RUN;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic dir_level = 1'b1;
  logic fall_req = 1'b0;
  wire logic hreadyout, hresp, ext_event_pin, count_in_pin, clock_out_pin, timer_irq, baud_tick;
  wire logic [31:0] hrdata;
  wire logic [7:0] hi_len, lo_len;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] v;
  int n;

  always #25 hclk = ~hclk;

  tmr_reload_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ext_event_pin(ext_event_pin), .count_in_pin(count_in_pin),
    .clock_out_pin(clock_out_pin), .timer_irq(timer_irq), .baud_tick(baud_tick));
  tmr_partner far_u (.hclk(hclk), .hresetn(hresetn), .dir_level(dir_level), .fall_req(fall_req),
    .clock_out_pin(clock_out_pin), .ext_event_pin(ext_event_pin), .count_in_pin(count_in_pin),
    .hi_len(hi_len), .lo_len(lo_len));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    mismatches++;
    $display("ERROR %0t wait ran out", $time);
    final_report();
  endtask

  // hready sampled just before each rising edge
  task automatic rdy(output logic [31:0] rd);
    logic s;
    int k;
    s = 1'b0;
    k = 0;
    while (s !== 1'b1) begin
      @(negedge hclk);
      s = hreadyout;
      rd = hrdata;
      @(posedge hclk);
      k++;
      if (k > 20) hang();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy(rd);
    htrans <= 2'h0;
    hwdata <= d;
    rdy(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0, x);
  endtask

  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (timer_irq !== 1'b1 && k < lim) begin
      @(negedge hclk);
      k++;
    end
    if (k >= lim) hang();
  endtask

  task automatic pulse_fall();
    @(posedge hclk);
    fall_req <= 1'b1;
    repeat (2) @(posedge hclk);
    fall_req <= 1'b0;
  endtask

  // cycles between two bit-rate ticks
  task automatic gap(output int g);
    int k;
    k = 0;
    while (baud_tick !== 1'b1 && k < 200) begin
      @(negedge hclk);
      k++;
    end
    g = 0;
    do begin
      @(negedge hclk);
      g++;
    end while (baud_tick !== 1'b1 && g < 200);
    if (k >= 200 || g >= 200) hang();
  endtask

  task automatic t_reset();
    rd(TMR_OFF_CTRL, v); check(v, 32'h0);
    rd(TMR_OFF_MODE, v); check(v, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, v); check(v, 32'h0);
    rd(TMR_OFF_CTRL, v); check(v, 32'h0);
    check({31'h0, timer_irq}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_up();
    wr(TMR_OFF_MODE, 32'h0C);
    wr(TMR_OFF_RELOAD, 32'hFFFE);
    wr(TMR_OFF_COUNT, 32'hFFFE);
    wr(TMR_OFF_CTRL, C_RUN);
    wait_irq(60);
    wr(TMR_OFF_CTRL, C_OVF);
    rd(TMR_OFF_COUNT, v); check(v, 32'hFFFE);
    rd(TMR_OFF_CTRL, v); check(v, C_OVF);
    @(negedge hclk);
    check({31'h0, timer_irq}, 32'h1);
    wr(TMR_OFF_VECTOR, 32'h1);
    rd(TMR_OFF_CTRL, v); check(v, 32'h0);
    @(negedge hclk);
    check({31'h0, timer_irq}, 32'h0);
    $display("up count test done");
  endtask

  task automatic t_ext();
    wr(TMR_OFF_RELOAD, 32'h1230);
    wr(TMR_OFF_COUNT, 32'h0);
    wr(TMR_OFF_CTRL, C_RUN | C_EXEN);
    pulse_fall();
    rd(TMR_OFF_COUNT, v); check({20'h0, v[15:4]}, 32'h123);
    rd(TMR_OFF_CTRL, v); check(v, C_EXT | C_RUN | C_EXEN);
    @(negedge hclk);
    check({31'h0, timer_irq}, 32'h1);
    wr(TMR_OFF_CTRL, 32'h0);
    $display("event reload test done");
  endtask

  task automatic t_updown();
    wr(TMR_OFF_MODE, 32'h0D);
    dir_level <= 1'b0;
    wr(TMR_OFF_RELOAD, 32'h0010);
    wr(TMR_OFF_COUNT, 32'h0011);
    wr(TMR_OFF_CTRL, C_RUN);
    wait_irq(80);
    rd(TMR_OFF_CTRL, v); check(v, C_OVF | C_EXT | C_RUN);
    wr(TMR_OFF_CTRL, C_EXT);
    rd(TMR_OFF_COUNT, v); check(v, 32'hFFFF);
    @(negedge hclk);
    check({31'h0, timer_irq}, 32'h0);
    dir_level <= 1'b1;
    wr(TMR_OFF_RELOAD, 32'h0005);
    wr(TMR_OFF_CTRL, C_RUN);
    wait_irq(60);
    rd(TMR_OFF_CTRL, v); check(v, C_OVF | C_EXT | C_RUN);
    wr(TMR_OFF_CTRL, 32'h0);
    rd(TMR_OFF_COUNT, v); check(v, 32'h0005);
    wr(TMR_OFF_MODE, 32'h0);
    $display("up/down test done");
  endtask

  task automatic t_baud();
    for (int p = 0; p < 4; p++) begin
      wr(TMR_OFF_CTRL, 32'h0);
      wr(TMR_OFF_MODE, 32'h2 | (32'(p) << TMR_MODE_PRE_LO));
      wr(TMR_OFF_RELOAD, 32'hFFFE);
      wr(TMR_OFF_COUNT, 32'hFFFE);
      wr(TMR_OFF_CTRL, C_SS | C_EXEN | C_RUN);
      gap(n);
      gap(n); check(32'(n), 32'(6 * (p + 1)));
      gap(n);
      check({24'h0, hi_len}, 32'(6 * (p + 1)));
      check({24'h0, lo_len}, 32'(6 * (p + 1)));
      check({31'h0, timer_irq}, 32'h0);
      pulse_fall();
      rd(TMR_OFF_CTRL, v); check(v, C_SS | C_EXT | C_EXEN | C_RUN);
    end
    wr(TMR_OFF_CTRL, 32'h0);
    wr(TMR_OFF_MODE, 32'h2);
    wr(TMR_OFF_CTRL, C_RUN);
    repeat (40) @(posedge hclk);
    @(negedge hclk);
    check({31'h0, timer_irq}, 32'h0);
    rd(TMR_OFF_CTRL, v); check(v, C_RUN);
    check({24'h0, hi_len}, 32'h6);
    wr(TMR_OFF_CTRL, 32'h0);
    $display("bit-rate and clock-out test done");
  endtask

  // stopped mode holds the count, capture mode wraps to zero with a flag
  task automatic t_stop();
    wr(TMR_OFF_MODE, 32'h2);
    wr(TMR_OFF_COUNT, 32'h1234);
    wr(TMR_OFF_CTRL, C_RUN | 32'h1);
    repeat (20) @(posedge hclk);
    rd(TMR_OFF_COUNT, v); check(v, 32'h1234);
    wr(TMR_OFF_CTRL, 32'h0);
    wr(TMR_OFF_MODE, 32'h0);
    wr(TMR_OFF_COUNT, 32'hFFFF);
    wr(TMR_OFF_CTRL, C_RUN | 32'h1);
    wait_irq(20);
    rd(TMR_OFF_CTRL, v); check(v, C_OVF | C_RUN | 32'h1);
    wr(TMR_OFF_CTRL, 32'h0);
    @(negedge hclk);
    check({31'h0, hresp}, 32'h0);
    $display("stopped and capture test done");
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_up();
    t_ext();
    t_updown();
    t_baud();
    t_stop();
    final_report();
  end
endmodule
`default_nettype wire
